// ===== audio_dma.sv
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`include "audio_dma_defines.svh"
module audio_dma (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_r,
   output logic pready_r,
   output logic pslverr_r,
   output logic irq_r,
   output audio_dma_pkg::mem_req_s mem_r,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   input wire logic rec_valid,
   input wire logic [31:0] rec_data,
   output logic rec_ready_r,
   input wire logic rec_fifo_full,
   output logic play_valid_r,
   output logic [31:0] play_data_r,
   input wire logic play_ready
);
   localparam int NREG = 10;
   localparam int I_RBASE = 0;
   localparam int I_RLEN = 1;
   localparam int I_RCUR = 2;
   localparam int I_RSTAT = 3;
   localparam int I_PBASE = 4;
   localparam int I_PLEN = 5;
   localparam int I_PCUR = 6;
   localparam int I_CTRL = 7;
   localparam int I_ISTAT = 8;
   localparam int I_IMASK = 9;

   logic [31:0] rec_base_r;
   logic [31:0] rec_len_r;
   logic [31:0] play_base_r;
   logic [31:0] play_len_r;
   logic [1:0] ctrl_r;
   logic [1:0] ctrl_d_r;
   logic [3:0] imask_r;
   logic [31:0] rec_cur;
   logic [31:0] play_cur;
   logic rec_mid;
   logic rec_end;
   logic play_mid;
   logic play_end;
   logic [1:0] rstat;
   logic [3:0] istat;
   logic [1:0] rstat_clr;
   logic [3:0] istat_clr;
   logic [NREG-1:0] sel;
   logic wr_en;
   logic rd_done;
   logic rec_step;
   logic play_step;
   logic rec_load;
   logic play_load;
   logic [31:0] rd_word;
   audio_dma_pkg::dma_state_e state_r;
   audio_dma_pkg::dma_state_e state_nxt;

   // Decodes a byte address into a one-hot register select.
   function automatic logic [NREG-1:0] decode(input logic [31:0] a);
      logic [NREG-1:0] s;
      s = '0;
      case (a)
         `REC_BASE_ADDR: s[I_RBASE] = 1'b1;
         `REC_LEN_ADDR: s[I_RLEN] = 1'b1;
         `REC_CUR_ADDR: s[I_RCUR] = 1'b1;
         `REC_STAT_ADDR: s[I_RSTAT] = 1'b1;
         `PLAY_BASE_ADDR: s[I_PBASE] = 1'b1;
         `PLAY_LEN_ADDR: s[I_PLEN] = 1'b1;
         `PLAY_CUR_ADDR: s[I_PCUR] = 1'b1;
         `DMA_CTRL_ADDR: s[I_CTRL] = 1'b1;
         `IRQ_STAT_ADDR: s[I_ISTAT] = 1'b1;
         `IRQ_MASK_ADDR: s[I_IMASK] = 1'b1;
         default: s = '0;
      endcase
      return s;
   endfunction

   assign sel = decode(paddr);
   assign wr_en = psel && penable && pready_r && pwrite;
   assign rd_done = psel && penable && pready_r && !pwrite;

   // Every access has exactly one wait-free access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && (sel == '0);
      end
   end

   always_comb begin
      rd_word = '0;
      unique case (1'b1)
         sel[I_RBASE]: rd_word = rec_base_r;
         sel[I_RLEN]: rd_word = rec_len_r;
         sel[I_RCUR]: rd_word = rec_cur; // R2
         sel[I_RSTAT]: rd_word = {29'h0, rec_fifo_full, rstat}; // R3
         sel[I_PBASE]: rd_word = play_base_r;
         sel[I_PLEN]: rd_word = play_len_r;
         sel[I_PCUR]: rd_word = play_cur; // R11
         sel[I_CTRL]: rd_word = {30'h0, ctrl_r};
         sel[I_ISTAT]: rd_word = {28'h0, istat};
         sel[I_IMASK]: rd_word = {28'h0, imask_r};
         default: rd_word = '0;
      endcase
   end

   // Read data is captured in the setup cycle and held through the access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= `REG_RESET;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_base_r <= `REG_RESET;
         rec_len_r <= `REG_RESET;
         play_base_r <= `REG_RESET;
         play_len_r <= `REG_RESET;
      end else if (wr_en) begin
         if (sel[I_RBASE]) begin
            rec_base_r <= pwdata; // R10
         end
         if (sel[I_RLEN]) begin
            rec_len_r <= pwdata; // R1
         end
         if (sel[I_PBASE]) begin
            play_base_r <= pwdata; // R8
         end
         if (sel[I_PLEN]) begin
            play_len_r <= pwdata; // R9
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 2'h0;
         imask_r <= 4'h0;
      end else if (wr_en) begin
         if (sel[I_CTRL]) begin
            ctrl_r <= pwdata[1:0];
         end
         if (sel[I_IMASK]) begin
            imask_r <= pwdata[3:0];
         end
      end
   end

   // Rising enable edges reload the current addresses from the bases.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_d_r <= 2'h0;
      end else begin
         ctrl_d_r <= ctrl_r;
      end
   end

   assign rec_load = ctrl_r[`CTRL_REC_EN_BIT] && !ctrl_d_r[`CTRL_REC_EN_BIT];
   assign play_load = ctrl_r[`CTRL_PLAY_EN_BIT] && !ctrl_d_r[`CTRL_PLAY_EN_BIT];
   assign rec_step = (state_r == audio_dma_pkg::ST_REC_WR) && mem_ack;
   assign play_step = (state_r == audio_dma_pkg::ST_PLAY_RD) && mem_ack;

   dma_channel rec_chan (
      .pclk(pclk),
      .presetn(presetn),
      .load(rec_load),
      .step(rec_step),
      .base(rec_base_r),
      .length(rec_len_r),
      .cur_r(rec_cur),
      .mid_hit_r(rec_mid),
      .end_hit_r(rec_end)
   );

   dma_channel play_chan (
      .pclk(pclk),
      .presetn(presetn),
      .load(play_load),
      .step(play_step),
      .base(play_base_r),
      .length(play_len_r),
      .cur_r(play_cur),
      .mid_hit_r(play_mid),
      .end_hit_r(play_end)
   );

   // Write one to clear; a zero leaves the flag alone.
   assign rstat_clr = (wr_en && sel[I_RSTAT]) ? pwdata[1:0] : 2'h0; // R5 R7

   sticky_flags #(.WIDTH(2)) rec_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set({rec_end, rec_mid}), // R4 R6
      .clr(rstat_clr),
      .flags_r(rstat)
   );

   // Only bits that were returned to software are cleared, so a set that lands
   // after the setup cycle survives until the next read.
   assign istat_clr = (rd_done && sel[I_ISTAT]) ? prdata_r[3:0] : 4'h0;

   sticky_flags #(.WIDTH(4)) irq_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set({play_end, play_mid, rec_end, rec_mid}),
      .clr(istat_clr),
      .flags_r(istat)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(istat & imask_r);
      end
   end

   // Record is served first because its FIFO overflows while play only underruns.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         audio_dma_pkg::ST_IDLE: begin
            if (ctrl_r[`CTRL_REC_EN_BIT] && !rec_load && rec_valid && !rec_ready_r) begin
               state_nxt = audio_dma_pkg::ST_REC_WR;
            end else if (ctrl_r[`CTRL_PLAY_EN_BIT] && !play_load) begin
               state_nxt = audio_dma_pkg::ST_PLAY_RD;
            end
         end
         audio_dma_pkg::ST_REC_WR: begin
            if (mem_ack) begin
               state_nxt = audio_dma_pkg::ST_IDLE;
            end
         end
         audio_dma_pkg::ST_PLAY_RD: begin
            if (mem_ack) begin
               state_nxt = audio_dma_pkg::ST_PLAY_OUT;
            end
         end
         audio_dma_pkg::ST_PLAY_OUT: begin
            if (play_ready) begin
               state_nxt = audio_dma_pkg::ST_IDLE;
            end
         end
         default: state_nxt = audio_dma_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= audio_dma_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_r <= '0;
      end else if (mem_r.req) begin
         if (mem_ack) begin
            mem_r.req <= 1'b0;
         end
      end else if (state_r == audio_dma_pkg::ST_IDLE && state_nxt == audio_dma_pkg::ST_REC_WR) begin
         mem_r.req <= 1'b1;
         mem_r.we <= 1'b1;
         mem_r.addr <= rec_cur; // R10
         mem_r.wdata <= rec_data;
      end else if (state_r == audio_dma_pkg::ST_IDLE && state_nxt == audio_dma_pkg::ST_PLAY_RD) begin
         mem_r.req <= 1'b1;
         mem_r.we <= 1'b0;
         mem_r.addr <= play_cur;
      end
   end

   // The record sample is accepted in the cycle its write is launched.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rec_ready_r <= 1'b0;
      end else begin
         rec_ready_r <= (state_r == audio_dma_pkg::ST_IDLE) && (state_nxt == audio_dma_pkg::ST_REC_WR);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         play_valid_r <= 1'b0;
         play_data_r <= `REG_RESET;
      end else if (play_step) begin
         play_valid_r <= 1'b1;
         play_data_r <= mem_rdata;
      end else if (play_valid_r && play_ready) begin
         play_valid_r <= 1'b0;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   rec_len_hold_a: assert property ($changed(rec_len_r) |-> $past(wr_en && sel[I_RLEN])) // R1
      else $error("record length changed without a write");
   rec_cur_ro_a: assert property ($changed(rec_cur) |-> $past(rec_step || rec_load)) // R2
      else $error("record current address changed without a transfer");
   fifo_full_read_a: assert property ((rd_done && sel[I_RSTAT]) |-> prdata_r[2] == $past(rec_fifo_full)) // R3
      else $error("record status full bit does not follow the FIFO");
   end_flag_set_a: assert property (rec_end |=> rstat[`STAT_END_BIT]) // R4
      else $error("record end flag not set");
   end_flag_hold_a: assert property ((rstat[1] && !rstat_clr[1]) |=> rstat[1]) // R5
      else $error("record end flag cleared without a write of one");
   mid_flag_set_a: assert property (rec_mid |=> rstat[`STAT_MID_BIT]) // R6
      else $error("record midpoint flag not set");
   mid_flag_clear_a: assert property ((rstat_clr[0] && !rec_mid) |=> !rstat[0]) // R7
      else $error("record midpoint flag not cleared by a write of one");
   play_base_hold_a: assert property ($changed(play_base_r) |-> $past(wr_en && sel[I_PBASE])) // R8
      else $error("play base changed without a write");
   play_len_hold_a: assert property ($changed(play_len_r) |-> $past(wr_en && sel[I_PLEN])) // R9
      else $error("play length changed without a write");
   rec_start_a: assert property (rec_load |=> rec_cur == $past(rec_base_r)) // R10
      else $error("record address did not start at base");
   play_cur_ro_a: assert property ($changed(play_cur) |-> $past(play_step || play_load)) // R11
      else $error("play current address changed without a transfer");
   end_addr_a: assert property (rec_end |-> $past(rec_cur) + `WORD_STEP == $past(rec_base_r + rec_len_r)) // R12
      else $error("record end flagged at the wrong address");

   rec_wrap_c: cover property (rec_end ##[1:40] rec_mid);
   irq_fire_c: cover property (rec_mid ##[1:4] irq_r);
   play_out_c: cover property (play_valid_r && play_ready);
   w1c_c: cover property (rstat[1] ##1 rstat_clr[1] ##1 !rstat[1]);
endmodule

// ===== audio_dma_defines.svh
`ifndef AUDIO_DMA_DEFINES_SVH
`define AUDIO_DMA_DEFINES_SVH
// What this block does
// R1 - Record length is a 32-bit software register the DMA never changes.
// R2 - Record current address is 32-bit, read only, software writes ignored.
// R3 - Record status bit 2 reads 1 while the record FIFO is full.
// R4 - Record status bit 1 sets when record address reaches the end address.
// R5 - Record end flag clears only by writing 1; writing 0 keeps it.
// R6 - Record status bit 0 sets when record address reaches the middle address.
// R7 - Record midpoint flag clears only by writing 1; writing 0 keeps it.
// R8 - Play base address is a 32-bit register only software changes.
// R9 - Play length is a 32-bit software register the DMA never changes.
// R10 - Record base address is software only; record DMA starts writing there.
// R11 - Play current address is readable by software but never written by it.
// R12 - Middle is base plus half length, end is base plus length, checked per transfer.
// R13 - On reaching the end the current address reloads to base, circularly.
`define REC_BASE_ADDR 32'hfff0_9008
`define REC_LEN_ADDR 32'hfff0_900c
`define REC_CUR_ADDR 32'hfff0_9010
`define REC_STAT_ADDR 32'hfff0_9014
`define PLAY_BASE_ADDR 32'hfff0_9018
`define PLAY_LEN_ADDR 32'hfff0_901c
`define PLAY_CUR_ADDR 32'hfff0_9020
`define DMA_CTRL_ADDR 32'hfff0_9040
`define IRQ_STAT_ADDR 32'hfff0_9044
`define IRQ_MASK_ADDR 32'hfff0_9048
`define REG_RESET 32'h0000_0000
`define WORD_STEP 32'h0000_0004
`define STAT_MID_BIT 0
`define STAT_END_BIT 1
`define STAT_FULL_BIT 2
`define CTRL_REC_EN_BIT 0
`define CTRL_PLAY_EN_BIT 1
`define IRQ_REC_MID_BIT 0
`define IRQ_REC_END_BIT 1
`define IRQ_PLAY_MID_BIT 2
`define IRQ_PLAY_END_BIT 3
`endif

// ===== audio_dma_pkg.sv
package audio_dma_pkg;
   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_s;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_REC_WR = 4'h2,
      ST_PLAY_RD = 4'h4,
      ST_PLAY_OUT = 4'h8
   } dma_state_e;
endpackage

// ===== sticky_flags.sv
`timescale 1ns/1ns
module sticky_flags #(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] set,
   input wire logic [WIDTH-1:0] clr,
   output logic [WIDTH-1:0] flags_r
);
   // A set in the same cycle as a clear wins, so no event is lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= '0;
      end else begin
         flags_r <= (flags_r & ~clr) | set;
      end
   end

   set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
      (set != '0) |=> ((flags_r & $past(set)) == $past(set)))
      else $error("sticky flag lost a set");
endmodule

// ===== dma_channel.sv
`timescale 1ns/1ns
`include "audio_dma_defines.svh"
module dma_channel (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire logic step,
   input wire logic [31:0] base,
   input wire logic [31:0] length,
   output logic [31:0] cur_r,
   output logic mid_hit_r,
   output logic end_hit_r
);
   logic [31:0] nxt;
   logic [31:0] mid_addr;
   logic [31:0] end_addr;

   assign nxt = cur_r + `WORD_STEP;
   assign mid_addr = base + {1'b0, length[31:1]}; // R12
   assign end_addr = base + length; // R12

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_r <= `REG_RESET;
      end else if (load) begin
         cur_r <= base; // R10
      end else if (step) begin
         cur_r <= (nxt == end_addr) ? base : nxt; // R13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mid_hit_r <= 1'b0;
         end_hit_r <= 1'b0;
      end else begin
         mid_hit_r <= step && !load && (nxt == mid_addr); // R12
         end_hit_r <= step && !load && (nxt == end_addr); // R12
      end
   end

   end_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
      (step && !load && nxt == end_addr) |=> (cur_r == $past(base)))
      else $error("current address did not reload to base at end");
endmodule

// ===== mem_model.sv
`timescale 1ns/1ns
module mem_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire audio_dma_pkg::mem_req_s mem,
   input wire logic [3:0] delay,
   output logic ack_r,
   output logic [31:0] rdata_r
);
   logic [3:0] cnt_r;
   // Read data is only meaningful with the answer to a read; otherwise, write answers included, it toggles so stale data is never mistaken for valid.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         ack_r <= 1'b0;
         rdata_r <= 32'h0;
      end else if (mem.req && !ack_r && cnt_r == delay) begin
         ack_r <= 1'b1;
         cnt_r <= 4'h0;
         rdata_r <= mem.we ? ~rdata_r : mem.addr ^ 32'ha5a5_0000;
      end else begin
         ack_r <= 1'b0;
         rdata_r <= ~rdata_r;
         if (mem.req && !ack_r) begin
            cnt_r <= cnt_r + 4'h1;
         end
      end
   end
endmodule

// ===== audio_dma_test.sv
`timescale 1ns/1ns
`include "audio_dma_defines.svh"
module audio_dma_test;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic rec_valid = 1'b0;
   logic [31:0] rec_data = 32'h0;
   logic rec_fifo_full = 1'b0;
   logic play_ready = 1'b0;
   logic [3:0] delay = 4'h0;
   logic [31:0] prdata_r, play_data_r, mem_rdata, q;
   logic pready_r, pslverr_r, irq_r, rec_ready_r, play_valid_r, mem_ack, e;
   audio_dma_pkg::mem_req_s mem_r;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;

   always #25 pclk = ~pclk;

   audio_dma i_audio_dma (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
      .irq_r(irq_r), .mem_r(mem_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rec_valid(rec_valid),
      .rec_data(rec_data), .rec_ready_r(rec_ready_r), .rec_fifo_full(rec_fifo_full),
      .play_valid_r(play_valid_r), .play_data_r(play_data_r), .play_ready(play_ready));

   mem_model i_mem_model (.pclk(pclk), .presetn(presetn), .mem(mem_r), .delay(delay), .ack_r(mem_ack),
      .rdata_r(mem_rdata));

   task conclude;
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_compared++;
      if (s !== x) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return pready_r;
         1: return rec_ready_r;
         2: return mem_ack;
         default: return play_valid_r;
      endcase
   endfunction

   // Values read right after an edge are those of the cycle just ended, since the design updates by NBA.
   task wait_for(input int k);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (sig(k) !== 1'b1 && n < 40);
      if (n == 40) chk("handshake", 32'h0, 32'h1);
   endtask

   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wait_for(0);
      q = prdata_r;
      e = pslverr_r;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task rd(input logic [31:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, q, x);
   endtask

   task t_reset;
      logic [31:0] regs [7];
      regs = '{`REC_BASE_ADDR, `REC_LEN_ADDR, `REC_CUR_ADDR, `REC_STAT_ADDR, `PLAY_BASE_ADDR, `PLAY_LEN_ADDR,
         `PLAY_CUR_ADDR};
      foreach (regs[i]) rd(regs[i], `REG_RESET, "reset value");
   endtask

   task t_rw;
      apb(1'b1, `PLAY_LEN_ADDR, 32'hffff_ffff);
      rd(`PLAY_LEN_ADDR, 32'hffff_ffff, "play_length all ones");
      apb(1'b1, `REC_BASE_ADDR, 32'h0000_1000);
      apb(1'b1, `REC_LEN_ADDR, 32'h0000_0010);
      apb(1'b1, `PLAY_BASE_ADDR, 32'h0000_2000);
      apb(1'b1, `PLAY_LEN_ADDR, 32'h0000_0008);
      rd(`REC_BASE_ADDR, 32'h0000_1000, "record_base");
      rd(`REC_LEN_ADDR, 32'h0000_0010, "record_length");
      rd(`PLAY_BASE_ADDR, 32'h0000_2000, "play_base");
      rd(`PLAY_LEN_ADDR, 32'h0000_0008, "play_length");
   endtask

   task t_ro;
      apb(1'b1, `REC_CUR_ADDR, 32'hffff_ffff);
      rd(`REC_CUR_ADDR, 32'h0, "record_current written");
      apb(1'b1, `PLAY_CUR_ADDR, 32'hffff_ffff);
      rd(`PLAY_CUR_ADDR, 32'h0, "play_current written");
      apb(1'b0, 32'hfff0_9030, 32'h0);
      chk("unmapped error", {31'h0, e}, 32'h1);
      chk("unmapped data", q, 32'h0);
      rec_fifo_full <= 1'b1;
      rd(`REC_STAT_ADDR, 32'h4, "fifo full set");
      rec_fifo_full <= 1'b0;
      rd(`REC_STAT_ADDR, 32'h0, "fifo full clear");
   endtask

   task rec_one(input logic [31:0] d, input logic [31:0] a);
      rec_valid <= 1'b1;
      rec_data <= d;
      wait_for(1);
      chk("record mem addr", mem_r.addr, a);
      chk("record mem data", mem_r.wdata, d);
      chk("record mem req we", {30'h0, mem_r.req, mem_r.we}, 32'h3);
      rec_valid <= 1'b0;
      wait_for(2);
      repeat (4) @(posedge pclk);
   endtask

   task t_rec;
      apb(1'b1, `IRQ_MASK_ADDR, 32'h1);
      apb(1'b1, `DMA_CTRL_ADDR, 32'h1);
      delay <= 4'h3;
      rec_one(32'h1111_0000, 32'h0000_1000);
      rd(`REC_CUR_ADDR, 32'h0000_1004, "record_current");
      rd(`REC_STAT_ADDR, 32'h0, "no flag early");
      delay <= 4'h0;
      rec_one(32'h2222_0000, 32'h0000_1004);
      chk("irq on mid", {31'h0, irq_r}, 32'h1);
      rd(`REC_STAT_ADDR, 32'h1, "mid flag");
      apb(1'b1, `REC_STAT_ADDR, 32'h0);
      rd(`REC_STAT_ADDR, 32'h1, "mid kept by 0");
      rd(`IRQ_STAT_ADDR, 32'h1, "irq status");
      rd(`IRQ_STAT_ADDR, 32'h0, "irq status cleared");
      chk("irq low", {31'h0, irq_r}, 32'h0);
      apb(1'b1, `REC_STAT_ADDR, 32'h1);
      rd(`REC_STAT_ADDR, 32'h0, "mid cleared by 1");
      rec_one(32'h3333_0000, 32'h0000_1008);
      apb(1'b1, `REC_STAT_ADDR, 32'h1);
      rec_one(32'h4444_0000, 32'h0000_100c);
      rd(`REC_STAT_ADDR, 32'h2, "end flag");
      rd(`REC_CUR_ADDR, 32'h0000_1000, "wrap to base");
      rd(`REC_LEN_ADDR, 32'h0000_0010, "length untouched");
      rd(`IRQ_STAT_ADDR, 32'h2, "masked end status");
      chk("masked irq low", {31'h0, irq_r}, 32'h0);
      apb(1'b1, `REC_STAT_ADDR, 32'h0);
      rd(`REC_STAT_ADDR, 32'h2, "end kept by 0");
      apb(1'b1, `REC_STAT_ADDR, 32'h2);
      rd(`REC_STAT_ADDR, 32'h0, "end cleared by 1");
      rec_one(32'h5555_0000, 32'h0000_1000);
      apb(1'b1, `DMA_CTRL_ADDR, 32'h0);
   endtask

   task t_play;
      delay <= 4'h2;
      apb(1'b1, `DMA_CTRL_ADDR, 32'h2);
      wait_for(3);
      chk("play data 0", play_data_r, 32'ha5a5_2000);
      chk("play mem addr", mem_r.addr, 32'h0000_2000);
      chk("play mem req we", {30'h0, mem_r.req, mem_r.we}, 32'h0);
      rd(`PLAY_CUR_ADDR, 32'h0000_2004, "play_current");
      rd(`PLAY_BASE_ADDR, 32'h0000_2000, "play_base kept");
      chk("play held", {31'h0, play_valid_r}, 32'h1);
      play_ready <= 1'b1;
      @(posedge pclk);
      play_ready <= 1'b0;
      wait_for(3);
      chk("play data 1", play_data_r, 32'ha5a5_2004);
      rd(`PLAY_CUR_ADDR, 32'h0000_2000, "play wrap");
      rd(`IRQ_STAT_ADDR, 32'hc, "play mid and end");
      rd(`PLAY_LEN_ADDR, 32'h0000_0008, "play length kept");
      apb(1'b1, `DMA_CTRL_ADDR, 32'h0);
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         conclude();
      end
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_rw();
      t_ro();
      t_rec();
      t_play();
      conclude();
   end
endmodule
